// >>> pkg/irq_ctrl_pkg.sv
// Package for the eight-input priority interrupt controller
package irq_ctrl_pkg;

    // Fixed opcode returned on the first acknowledge pulse in call mode
    localparam logic [7:0] CALL_OPCODE   = 8'hCD;
    // Write steering bits of a word written with register select low
    localparam int         SEL_INIT_BIT  = 4;
    localparam int         SEL_OP3_BIT   = 3;
    // Init word 1 field positions
    localparam int         IW1_NEED_W4   = 0;
    localparam int         IW1_SINGLE    = 1;
    localparam int         IW1_INTERVAL4 = 2;
    localparam int         IW1_LEVEL     = 3;
    // Init word 4 field positions
    localparam int         IW4_POINTER   = 0;
    localparam int         IW4_AUTO_EOS  = 1;
    localparam int         IW4_MASTER    = 2;
    localparam int         IW4_BUFFERED  = 3;
    // Op word 2 fields: rotate, specific, end of service, level
    localparam int         OW2_ROTATE    = 7;
    localparam int         OW2_SPECIFIC  = 6;
    localparam int         OW2_EOS       = 5;
    // Op word 3 fields: poll, read enable, read in-service select
    localparam int         OW3_POLL      = 2;
    localparam int         OW3_READ_EN   = 1;
    localparam int         OW3_READ_ISR  = 0;
    // Level answered when a request vanished before the first acknowledge
    localparam logic [2:0] SPURIOUS_LEVEL = 3'h7;
    // Values after reset
    localparam logic [7:0] MASK_RESET    = 8'h00;
    localparam logic [2:0] PRIO_BASE_RST = 3'h0;

    // Init sequencer states
    typedef enum logic [3:0] {
        ST_WORD2 = 4'h1,
        ST_WORD3 = 4'h2,
        ST_WORD4 = 4'h4,
        ST_READY = 4'h8
    } init_state_t;

    // Synchronised host bus sample
    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       reg_select;
        logic [7:0] data;
    } bus_sample_t;

    // Programmed configuration
    typedef struct packed {
        logic [7:0] init_word_1;
        logic [7:0] init_word_2;
        logic [7:0] init_word_3;
        logic [7:0] init_word_4;
    } cfg_t;

endpackage

// >>> rtl/eight_input_priority_irq_ctrl.sv
// Eight-input priority interrupt controller with cascade and acknowledge sequencing
// Function
// - Latch each request input into its request latch bit: while high in level mode, on a rise in edge mode.
// - Interrupt output high while an unmasked winning request is pending.
// - Each owned acknowledge pulse places call opcode or vector bytes on data bus.
// - Cascade lines are outputs on master outside single mode, sampled inputs on slave.
// - Master lets addressed slave drive bytes two and three, itself stays off.
// - Non-buffered mode: role pin input, high master, low slave.
// - Buffered mode: role pin output, low while data bus is driven.
// - Chip select gates register access only; acknowledges work regardless.
// - Read returns level while poll is set, else request or in-service at select 0, mask at 1.
// - Select 0 writes steered by bits 4 and 3; select 1 loads sequence.
// - Priority and mask may change any time without reinitialisation.
// - Master with slaves resolves up to 64 levels.
// - Call mode: opcode, low, high byte; third pulse sets service, clears request.
// - Pointer mode: float on first pulse, drive 8-bit pointer on second.
// - Auto end of service clears service bit at last pulse trailing edge.
// - Request gone before first acknowledge answers level 7, no service bit.
`timescale 1ns/100ps
`default_nettype none
module eight_input_priority_irq_ctrl
    import irq_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // Host bus
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       reg_select,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    // Requests and acknowledge
    input  wire logic [7:0] irq_in,
    input  wire logic       irq_ack_n,
    output logic            int_out,
    // Cascade lines
    input  wire logic [2:0] cascade_lines_in,
    output logic      [2:0] cascade_lines_out,
    output logic            cascade_lines_oe,
    // Role pin or buffer enable
    input  wire logic       role_or_buf_enable_in,
    output logic            role_or_buf_enable_out,
    output logic            role_or_buf_enable_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic [1:0]  rst_sync;
    logic        rst_n;
    bus_sample_t bus_s1, bus_s2, bus_prev;
    logic [7:0]  irq_s1, irq_s2, irq_prev;
    logic [2:0]  cas_s1, cas_s2;
    logic        ack_s1, ack_s2, ack_prev, role_s1, role_s2;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Two flip-flops on every pin, then one more stage for edge detection on bus, request and acknowledge pins
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_s1   <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            bus_s2   <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            bus_prev <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            {irq_s1, irq_s2, irq_prev} <= 24'h000000;
            {ack_s1, ack_s2, ack_prev} <= 3'h7;
            {cas_s1, cas_s2}           <= 6'h00;
            {role_s1, role_s2}         <= 2'h0;                   // Slave until strap seen
        end
        else
        begin
            bus_s1   <= '{cs_n, rd_n, wr_n, reg_select, data_in};
            bus_s2   <= bus_s1;
            bus_prev <= bus_s2;
            {irq_s1, irq_s2, irq_prev} <= {irq_in, irq_s1, irq_s2};
            {ack_s1, ack_s2, ack_prev} <= {irq_ack_n, ack_s1, ack_s2};
            {cas_s1, cas_s2}           <= {cascade_lines_in, cas_s1};
            {role_s1, role_s2}         <= {role_or_buf_enable_in, role_s1};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and state
    cfg_t        cfg;
    init_state_t state;
    logic [7:0]  request_latch_reg, in_service_reg, mask_reg, op_word_3;
    logic [2:0]  prio_base, ack_level, slave_id;
    logic [1:0]  ack_cnt;
    logic        spurious, ack_own, last_done, poll_hold;

    // Function that walks priorities from the base and finds the winner
    function automatic logic [3:0] resolve(input logic [7:0] req, input logic [7:0] srv,
                                           input logic [2:0] base);
        logic [2:0] idx;
        logic       stop;
        logic [3:0] res;
        res  = 4'h0;
        stop = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            idx = base + 3'(i);
            if (!stop && srv[idx])
                stop = 1'b1;
            else if (!stop && req[idx])
            begin
                res  = {1'b1, idx};
                stop = 1'b1;
            end
        end
        return res;
    endfunction

    // Decoded modes, strobes and winner
    logic       wr_done, rd_active, ack_fall, ack_rise, is_master, single, pointer_mode;
    logic       buffered, is_last, own_byte, cascaded, poll_rd_end;
    logic [3:0] win, srv_top;
    logic [7:0] low_byte, pointer, rd_value, ack_value, rise;
    assign wr_done   = bus_s2.wr_n && !bus_prev.wr_n && !bus_prev.cs_n;
    assign rd_active = !bus_s2.cs_n && !bus_s2.rd_n && bus_s2.wr_n;
    assign poll_rd_end = bus_s2.rd_n && !bus_prev.rd_n && !bus_prev.cs_n;
    assign ack_fall  = !ack_s2 && ack_prev;
    assign ack_rise  = ack_s2 && !ack_prev;
    assign single       = cfg.init_word_1[IW1_SINGLE];
    assign pointer_mode = cfg.init_word_4[IW4_POINTER];
    assign buffered     = cfg.init_word_4[IW4_BUFFERED];
    assign is_master = buffered ? cfg.init_word_4[IW4_MASTER] : role_s2;
    assign slave_id  = cfg.init_word_3[2:0];
    assign cascaded  = is_master && !single && cfg.init_word_3[ack_level];
    assign rise      = irq_s2 & ~irq_prev;
    assign win       = resolve(request_latch_reg & ~mask_reg, in_service_reg, prio_base);
    assign srv_top   = resolve(in_service_reg, 8'h00, prio_base);
    assign is_last   = pointer_mode ? (ack_cnt == 2'h1) : (ack_cnt == 2'h2);
    // Vector bytes: interval 4 or 8 low byte, pointer with level in low bits
    assign low_byte  = cfg.init_word_1[IW1_INTERVAL4]
                     ? {cfg.init_word_1[7:5], ack_level, 2'h0}
                     : {cfg.init_word_1[7:6], ack_level, 3'h0};
    assign pointer   = {cfg.init_word_2[7:3], ack_level};
    // Byte owner: master off the bus for slave-supplied bytes
    assign own_byte  = (ack_cnt == 2'h0) ? (!pointer_mode && (is_master || single))
                     : (single || (is_master ? !cascaded : (cas_s2 == slave_id)));
    assign ack_value = (ack_cnt == 2'h0) ? CALL_OPCODE
                     : pointer_mode ? pointer
                     : (ack_cnt == 2'h1) ? low_byte : cfg.init_word_2;
    assign rd_value  = op_word_3[OW3_POLL] ? {win[3], 4'h0, win[2:0]}
                     : bus_s2.reg_select ? mask_reg
                     : op_word_3[OW3_READ_ISR] ? in_service_reg : request_latch_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and init sequence
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg       <= '0;
            state     <= ST_READY;
            mask_reg  <= MASK_RESET;
            op_word_3 <= 8'h02;
        end
        else if (wr_done && !bus_prev.reg_select && bus_prev.data[SEL_INIT_BIT])
        begin
            cfg.init_word_1 <= bus_prev.data;
            mask_reg        <= MASK_RESET;
            op_word_3       <= 8'h02;
            state           <= ST_WORD2;
        end
        else if (wr_done && !bus_prev.reg_select && bus_prev.data[SEL_OP3_BIT])
            op_word_3 <= bus_prev.data;
        else if (wr_done && bus_prev.reg_select)
        begin
            case (state)
                ST_WORD2:
                begin
                    cfg.init_word_2 <= bus_prev.data;
                    state <= ST_READY;
                    if (!single)
                        state <= ST_WORD3;
                    else if (cfg.init_word_1[IW1_NEED_W4])
                        state <= ST_WORD4;
                end
                ST_WORD3:
                begin
                    cfg.init_word_3 <= bus_prev.data;
                    state <= cfg.init_word_1[IW1_NEED_W4] ? ST_WORD4 : ST_READY;
                end
                ST_WORD4:
                begin
                    cfg.init_word_4 <= bus_prev.data;
                    state <= ST_READY;
                end
                default:
                    mask_reg <= bus_prev.data;
            endcase
        end
        else if (poll_rd_end && op_word_3[OW3_POLL])
            op_word_3[OW3_POLL] <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request latch, in-service, priority rotation and acknowledge sequence
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            request_latch_reg <= 8'h00;
            in_service_reg    <= 8'h00;
            prio_base         <= PRIO_BASE_RST;
            {ack_cnt, ack_level, spurious, last_done} <= 7'h00;
        end
        else
        begin
            // Level mode follows the pin; edge mode needs a fresh rise
            if (cfg.init_word_1[IW1_LEVEL])
                request_latch_reg <= irq_s2;
            else
                request_latch_reg <= (request_latch_reg | rise) & irq_s2;
            if (wr_done && !bus_prev.reg_select && bus_prev.data[SEL_INIT_BIT])
            begin
                in_service_reg <= 8'h00;
                prio_base      <= PRIO_BASE_RST;
                ack_cnt        <= 2'h0;
            end
            else if (wr_done && !bus_prev.reg_select && !bus_prev.data[SEL_OP3_BIT])
            begin
                // End of service commands and priority rotation
                if (bus_prev.data[OW2_EOS] && bus_prev.data[OW2_SPECIFIC])
                    in_service_reg[bus_prev.data[2:0]] <= 1'b0;
                else if (bus_prev.data[OW2_EOS] && srv_top[3])
                    in_service_reg[srv_top[2:0]] <= 1'b0;
                if (bus_prev.data[OW2_ROTATE] && bus_prev.data[OW2_SPECIFIC])
                    prio_base <= bus_prev.data[2:0] + 3'h1;
                else if (bus_prev.data[OW2_ROTATE] && bus_prev.data[OW2_EOS])
                    prio_base <= srv_top[2:0] + 3'h1;
            end
            else if (poll_rd_end && op_word_3[OW3_POLL] && win[3])
            begin
                in_service_reg[win[2:0]]    <= 1'b1;
                request_latch_reg[win[2:0]] <= rise[win[2:0]];
            end
            // Acknowledge pulses, taken with or without chip select
            if (ack_fall)
            begin
                if (ack_cnt == 2'h0)
                begin
                    ack_level <= win[3] ? win[2:0] : SPURIOUS_LEVEL;
                    spurious  <= !win[3];
                end
                if (is_last)
                begin
                    ack_cnt   <= 2'h0;
                    last_done <= 1'b1;
                    if (!spurious)
                    begin
                        in_service_reg[ack_level]    <= 1'b1;
                        request_latch_reg[ack_level] <= rise[ack_level];
                    end
                end
                else
                    ack_cnt <= ack_cnt + 2'h1;
            end
            else if (ack_rise && last_done)
            begin
                last_done <= 1'b0;
                if (cfg.init_word_4[IW4_AUTO_EOS])
                    in_service_reg[ack_level] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered pin drivers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {data_out, data_oe, int_out, ack_own} <= 11'h000;
            cascade_lines_out      <= 3'h0;
            cascade_lines_oe       <= 1'b0;
            role_or_buf_enable_out <= 1'b1;
            role_or_buf_enable_oe  <= 1'b0;
        end
        else
        begin
            int_out <= win[3];
            if (ack_fall)
                ack_own <= own_byte;
            else if (ack_rise)
                ack_own <= 1'b0;
            // Float unless a read or an owned acknowledge byte is live
            data_oe  <= rd_active || (ack_fall ? own_byte : (ack_own && !ack_s2));
            // Acknowledge byte frozen at pulse start, the count moves on at that edge
            data_out <= rd_active ? rd_value : (ack_fall ? ack_value : data_out);
            cascade_lines_oe  <= is_master && !single;
            cascade_lines_out <= win[3] && ack_cnt == 2'h0 ? win[2:0] : ack_level;
            role_or_buf_enable_oe  <= buffered;
            role_or_buf_enable_out <= !(rd_active
                                      || (ack_fall ? own_byte : (ack_own && !ack_s2)));
        end
    end

endmodule
`default_nettype wire

// >>> tb/irq_ctrl_assertions.sv
// Port checker for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module irq_ctrl_checker
(
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       reset_n,
    // Host bus and acknowledge
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       irq_ack_n,
    input wire logic [7:0] irq_in,
    // Device outputs
    input wire logic       data_oe,
    input wire logic       int_out,
    input wire logic       cascade_lines_oe,
    input wire logic       role_or_buf_enable_in,
    input wire logic       role_or_buf_enable_out,
    input wire logic       role_or_buf_enable_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Bus activity that may legally make the device drive
    wire idle;
    wire act;
    assign idle = irq_ack_n && (cs_n || rd_n || !wr_n);
    assign act  = !irq_ack_n || (!cs_n && !rd_n && wr_n);

    a_bus_float_idle: assert property (idle [*5] |-> !data_oe)
        else $error("data bus driven while idle");
    a_read_drives_bus: assert property ((!cs_n && !rd_n && wr_n && irq_ack_n) [*5] |-> data_oe)
        else $error("read not answered");
    a_drive_has_cause: assert property ($rose(data_oe) |-> $past(act, 2) || $past(act, 3) || $past(act, 4))
        else $error("data bus driven without read or acknowledge");
    a_buf_enable_low: assert property (role_or_buf_enable_oe |-> role_or_buf_enable_out == !data_oe)
        else $error("buffer enable does not follow data drive");
    a_int_has_request: assert property ($rose(int_out) |-> $past(|irq_in, 2) || $past(|irq_in, 3) || $past(|irq_in, 4) || $past(|irq_in, 5))
        else $error("interrupt raised without request");
    a_int_quiet_low: assert property ((irq_in == 8'h00) [*8] |-> !int_out)
        else $error("interrupt high with no request");
    a_slave_no_cascade: assert property ((!role_or_buf_enable_oe && !role_or_buf_enable_in) [*4] |-> !cascade_lines_oe)
        else $error("slave drives cascade lines");
    a_reset_outputs_off: assert property ($rose(reset_n) |-> !data_oe && !int_out)
        else $error("outputs active at reset release");

    c_int: cover property ($rose(int_out));
    c_ack_drive: cover property (data_oe && !irq_ack_n);
    c_buffered: cover property (role_or_buf_enable_oe && data_oe);
endmodule
bind eight_input_priority_irq_ctrl irq_ctrl_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .irq_ack_n(irq_ack_n), .irq_in(irq_in),
    .data_oe(data_oe), .int_out(int_out), .cascade_lines_oe(cascade_lines_oe),
    .role_or_buf_enable_in(role_or_buf_enable_in), .role_or_buf_enable_out(role_or_buf_enable_out),
    .role_or_buf_enable_oe(role_or_buf_enable_oe));
`default_nettype wire

// >>> tb/host_ack_model.sv
// Host processor model issuing acknowledge pulses and sampling the data bus
`timescale 1ns/100ps
`default_nettype none
module host_ack_model
(
    // Clock
    input  wire logic       ref_clk,
    // Data bus from the device
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    // Acknowledge strobe
    output var logic        irq_ack_n
);
    logic [7:0] last = 8'h00;
    logic [7:0] bus;
    initial
    begin
        irq_ack_n = 1'b1;
    end
    // A floating bus shows the inverse of the last byte driven
    assign bus = data_oe ? data_out : ~last;
    always @(posedge ref_clk)
        if (data_oe)
            last <= data_out;
    // One pulse, byte taken late in the low phase, then a long high phase
    task automatic pulse(output logic [7:0] d, output logic oe);
        @(negedge ref_clk);
        irq_ack_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        d = bus;
        oe = data_oe;
        irq_ack_n = 1'b1;
        repeat (6) @(negedge ref_clk);
    endtask
endmodule
`default_nettype wire

// >>> tb/eight_input_priority_irq_ctrl_test.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module eight_input_priority_irq_ctrl_test;
    import irq_ctrl_pkg::*;
    logic       ref_clk, reset_n, cs_n, rd_n, wr_n, reg_select, role_in;
    logic [7:0] data_in, irq_in, data_out;
    logic       data_oe, int_out, irq_ack_n, role_out, role_oe, cas_oe;
    logic [2:0] cas_in, cas_out;
    int         fails, n_checks;

    eight_input_priority_irq_ctrl u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .reg_select(reg_select), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .irq_in(irq_in), .irq_ack_n(irq_ack_n),
        .int_out(int_out), .cascade_lines_in(cas_in), .cascade_lines_out(cas_out),
        .cascade_lines_oe(cas_oe), .role_or_buf_enable_in(role_in),
        .role_or_buf_enable_out(role_out), .role_or_buf_enable_oe(role_oe));
    host_ack_model u_host (.ref_clk(ref_clk), .data_out(data_out), .data_oe(data_oe),
        .irq_ack_n(irq_ack_n));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(logic sel, logic [7:0] d, logic cs = 1'b0);
        @(negedge ref_clk);
        cs_n = cs;
        reg_select = sel;
        data_in = d;
        wr_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        wr_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        cs_n = 1'b1;
    endtask
    task automatic rd(logic sel, logic [7:0] exp, string name, logic cs = 1'b0);
        @(negedge ref_clk);
        reg_select = sel;
        cs_n = cs;
        rd_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        check("data_oe", !cs, data_oe);
        if (!cs)
            check(name, exp, data_out);
        rd_n = 1'b1;
        cs_n = 1'b1;
        repeat (5) @(negedge ref_clk);
    endtask
    task automatic ack(logic exp_oe, logic [7:0] exp, string name);
        logic [7:0] d;
        logic       oe;
        u_host.pulse(d, oe);
        check("ack_oe", exp_oe, oe);
        if (exp_oe)
            check(name, exp, d);
    endtask
    task automatic wait_int(logic exp);
        for (int i = 0; i < 30 && int_out !== exp; i++)
            @(negedge ref_clk);
        check("int_out", exp, int_out);
    endtask
    task automatic call3(logic [7:0] low);
        ack(1'b1, CALL_OPCODE, "opcode");
        ack(1'b1, low, "vec_low");
        ack(1'b1, 8'hA8, "vec_high");
    endtask
    task automatic init(logic [7:0] w4, logic [7:0] w1 = 8'h17, logic [7:0] w3 = 8'h00);
        wr(1'b0, w1);
        wr(1'b1, 8'hA8);
        if (!w1[IW1_SINGLE])
            wr(1'b1, w3);
        wr(1'b1, w4);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs;
        init(8'h00);
        wr(1'b1, 8'h5A);
        rd(1'b1, 8'h5A, "mask");
        wr(1'b1, 8'h33, 1'b1);
        rd(1'b1, 8'h5A, "mask_cs_high");
        rd(1'b1, 8'h00, "no_select", 1'b1);
        wr(1'b1, 8'h00);
    endtask
    task automatic t_call;
        irq_in = 8'h08;
        wait_int(1'b1);
        call3(8'h0C);
        irq_in = 8'h00;
        wr(1'b0, 8'h0B);
        rd(1'b0, 8'h08, "in_service");
        wr(1'b0, 8'h20);
        rd(1'b0, 8'h00, "in_service_eos");
    endtask
    task automatic t_prio;
        wr(1'b1, 8'h01);
        irq_in = 8'h21;
        wait_int(1'b1);
        call3(8'h14);
        irq_in = 8'h00;
        wr(1'b0, 8'h20);
        wr(1'b1, 8'hFF);
        irq_in = 8'h10;
        repeat (10) @(negedge ref_clk);
        check("int_masked", 1'b0, int_out);
        wr(1'b0, 8'h0A);
        rd(1'b0, 8'h10, "request_latch");
        irq_in = 8'h00;
        wr(1'b1, 8'h00);
    endtask
    task automatic t_spur;
        irq_in = 8'h04;
        wait_int(1'b1);
        irq_in = 8'h00;
        repeat (8) @(negedge ref_clk);
        call3(8'h1C);
        wr(1'b0, 8'h0B);
        rd(1'b0, 8'h00, "in_service_spur");
    endtask
    task automatic t_ptr;
        init(8'h0B);
        check("role_oe", 1'b1, role_oe);
        check("role_out", 1'b1, role_out);
        irq_in = 8'h40;
        wait_int(1'b1);
        ack(1'b0, 8'h00, "ptr_first");
        irq_in = 8'h00;
        ack(1'b1, 8'hAE, "pointer");
        wr(1'b0, 8'h0B);
        rd(1'b0, 8'h00, "in_service_auto");
    endtask
    // Level mode: a held request asks again once its service ends
    task automatic t_level;
        init(8'h00, 8'h1F);
        irq_in = 8'h02;
        wait_int(1'b1);
        call3(8'h04);
        wr(1'b0, 8'h20);
        wait_int(1'b1);
        irq_in = 8'h00;
        wait_int(1'b0);
    endtask
    // Cascade: slave answers bytes two and three, master stays off them
    task automatic t_cas;
        cas_in = 3'h2;
        init(8'h00, 8'h15, 8'h02);
        check("cas_oe_slave", 1'b0, cas_oe);
        irq_in = 8'h40;
        wait_int(1'b1);
        ack(1'b0, 8'h00, "slave_op");
        ack(1'b1, 8'h18, "slave_low");
        ack(1'b1, 8'hA8, "slave_high");
        irq_in = 8'h00;
        wr(1'b0, 8'h20);
        role_in = 1'b1;
        init(8'h00, 8'h15, 8'h40);
        check("cas_oe_master", 1'b1, cas_oe);
        irq_in = 8'h40;
        wait_int(1'b1);
        ack(1'b1, CALL_OPCODE, "master_op");
        check("cas_out", 8'h06, {5'h00, cas_out});
        ack(1'b0, 8'h00, "master_low");
        ack(1'b0, 8'h00, "master_high");
        irq_in = 8'h00;
        wr(1'b0, 8'h20);
    endtask
    task automatic test_done;
        $display("Checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and main sequence
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial
    begin
        #40000;
        fails++;
        test_done();
    end
    initial
    begin
        fails = 0;
        n_checks = 0;
        reset_n = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        reg_select = 1'b0;
        data_in = 8'h00;
        irq_in = 8'h00;
        role_in = 1'b0;
        cas_in = 3'h0;
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        t_regs();
        t_call();
        t_prio();
        t_spur();
        t_level();
        t_ptr();
        t_cas();
        test_done();
    end
endmodule
`default_nettype wire
